//--- src/adc_timing_pkg.sv
package adc_timing_pkg;
    // Clock period in picoseconds (25 MHz)
    localparam int unsigned CLK_PERIOD_PS     = 40000;
    localparam int unsigned CONV_TIME_NS      = 1000;
    localparam int unsigned MIN_START_NS      = 500;
    localparam int unsigned VALID_LOW_NS      = 100;
    // Latency rounds down, low time rounds up, none below one cycle
    localparam int unsigned CONV_CYC_RAW      = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CONV_CYC          = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
    // Shortest whole cycle spacing that lies beyond the minimum start time
    localparam int unsigned MIN_START_CYC     = (MIN_START_NS * 1000) / CLK_PERIOD_PS + 1;
    localparam int unsigned VALID_LOW_CYC_RAW = (VALID_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned VALID_LOW_CYC     = (VALID_LOW_CYC_RAW < 1) ? 1 : VALID_LOW_CYC_RAW;
    localparam int unsigned DATA_W_MAX        = 32;
    localparam int unsigned SLOTS             = 4;
    localparam int unsigned CNT_W             = 16;
    // Strobe synchroniser stages ahead of the edge detect
    localparam int unsigned SYNC_STAGES       = 2;

    typedef struct packed {
        logic [DATA_W_MAX-1:0] code;
        logic                  valid_n;
    } result_t;
endpackage : adc_timing_pkg

//--- src/adc_code_fmt.sv
`timescale 1ns/10ps
module adc_code_fmt #(
    parameter int unsigned DATA_W = 8
) (
    input  wire logic [DATA_W-1:0] raw_code,  // Unsigned sampled code
    input  wire logic              twos_comp, // Two's complement select
    output logic      [DATA_W-1:0] fmt_code   // Formatted code
);
    // Offset binary to two's complement is an MSB flip
    always_comb begin
        fmt_code = raw_code;
        if (twos_comp) begin
            fmt_code[DATA_W-1] = ~raw_code[DATA_W-1];
        end
    end
endmodule : adc_code_fmt

//--- src/adc_conversion_timing.sv
`timescale 1ns/10ps
//
// What this block does
// - Strobe rising edge samples the analogue input and starts a conversion
// - Result bus updates exactly one conversion latency after the start
// - Ready flag goes low on update and back high after the low time
// - Starts overlap if spaced more than the minimum start spacing
// - A start within the minimum spacing is ignored and yields nothing
// - Result width one to thirty-two bits, all bits presented together
// - Format select: two's complement when set, offset binary when clear
module adc_conversion_timing
    import adc_timing_pkg::*;
#(
    parameter int unsigned DATA_W    = 8,
    parameter int unsigned CONV_C    = CONV_CYC,
    parameter int unsigned MINSP_C   = MIN_START_CYC,
    parameter int unsigned VLOW_C    = VALID_LOW_CYC
) (
    input  wire logic              clk_sys,    // System clock 25 MHz
    input  wire logic              rst_b,      // Async reset, active low
    input  wire logic              strobe_in,  // Sample strobe pin
    input  wire logic [DATA_W-1:0] sample_in,  // Quantised analogue value
    input  wire logic              twos_comp,  // Output format select
    output logic      [DATA_W-1:0] data_out,   // Result bus
    output logic                   data_valid  // Result ready, low after update
);
    // Due count allows for the synchroniser delay ahead of accept
    localparam int unsigned      DUE_C   = (CONV_C > SYNC_STAGES) ? CONV_C - SYNC_STAGES : 1;
    localparam logic [CNT_W-1:0] DUE_L   = CNT_W'(DUE_C);
    localparam logic [CNT_W-1:0] MINSP_L = CNT_W'(MINSP_C);
    localparam logic [CNT_W-1:0] VLOW_L  = CNT_W'(VLOW_C);
    localparam int unsigned      PTR_W   = $clog2(SLOTS);

    ////////////////////////////////////////////////////////////////////////
    // Strobe synchroniser and edge detect
    logic              sync1_ff, sync2_ff, sync3_ff;
    logic              nxt_sync1, nxt_sync2, nxt_sync3;
    logic              rise;

    always_comb begin
        nxt_sync1 = strobe_in;
        nxt_sync2 = sync1_ff;
        nxt_sync3 = sync2_ff;
        rise      = sync2_ff & ~sync3_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            sync3_ff <= nxt_sync3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spacing check and in-flight slots
    logic [CNT_W-1:0]  since_ff, nxt_since;
    logic              seen_ff, nxt_seen;
    logic [DATA_W-1:0] smp_ff [SLOTS];
    logic [DATA_W-1:0] nxt_smp [SLOTS];
    logic [CNT_W-1:0]  due_ff [SLOTS];
    logic [CNT_W-1:0]  nxt_due [SLOTS];
    logic [SLOTS-1:0]  busy_ff, nxt_busy;
    logic [PTR_W-1:0]  wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic              accept, deliver;
    logic [DATA_W-1:0] fmt_code;

    always_comb begin
        // Accept from the first legal spacing on
        accept    = rise && (!seen_ff || since_ff >= MINSP_L) && !busy_ff[wr_ff];
        deliver   = busy_ff[rd_ff] && (due_ff[rd_ff] == DUE_L);
        nxt_since = (since_ff == '1) ? since_ff : since_ff + 1'b1;
        nxt_seen  = seen_ff;
        nxt_busy  = busy_ff;
        nxt_wr    = wr_ff;
        nxt_rd    = rd_ff;
        for (int i = 0; i < SLOTS; i++) begin
            nxt_smp[i] = smp_ff[i];
            nxt_due[i] = busy_ff[i] ? due_ff[i] + 1'b1 : due_ff[i];
        end
        if (deliver) begin
            nxt_busy[rd_ff] = 1'b0;
            nxt_rd          = rd_ff + 1'b1;
        end
        if (accept) begin
            nxt_smp[wr_ff]  = sample_in;
            nxt_due[wr_ff]  = CNT_W'(1);
            nxt_busy[wr_ff] = 1'b1;
            nxt_wr          = wr_ff + 1'b1;
            nxt_since       = CNT_W'(1);
            nxt_seen        = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            since_ff <= '0;
            seen_ff  <= 1'b0;
            busy_ff  <= '0;
            wr_ff    <= '0;
            rd_ff    <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                smp_ff[i] <= '0;
                due_ff[i] <= '0;
            end
        end else begin
            since_ff <= nxt_since;
            seen_ff  <= nxt_seen;
            busy_ff  <= nxt_busy;
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
            for (int i = 0; i < SLOTS; i++) begin
                smp_ff[i] <= nxt_smp[i];
                due_ff[i] <= nxt_due[i];
            end
        end
    end

    adc_code_fmt #(.DATA_W(DATA_W)) u_fmt (
        .raw_code  (smp_ff[rd_ff]),
        .twos_comp (twos_comp),
        .fmt_code  (fmt_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Result bus and ready flag
    logic [DATA_W-1:0] out_ff, nxt_out;
    logic              vld_ff, nxt_vld;
    logic [CNT_W-1:0]  low_ff, nxt_low;

    always_comb begin
        nxt_out = out_ff;
        nxt_vld = vld_ff;
        nxt_low = low_ff;
        if (deliver) begin
            nxt_out = fmt_code;
            nxt_vld = 1'b0;
            nxt_low = VLOW_L;
        end else if (!vld_ff) begin
            nxt_low = low_ff - 1'b1;
            if (low_ff == CNT_W'(1)) begin
                nxt_vld = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= '0;
            vld_ff <= 1'b1;
            low_ff <= '0;
        end else begin
            out_ff <= nxt_out;
            vld_ff <= nxt_vld;
            low_ff <= nxt_low;
        end
    end

    assign data_out   = out_ff;
    assign data_valid = vld_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [CNT_W-1:0] lowrun_ff;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lowrun_ff <= '0;
        end else begin
            lowrun_ff <= vld_ff ? '0 : lowrun_ff + 1'b1;
        end
    end

    a_accept_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rise && seen_ff && since_ff < MINSP_L |=> wr_ff == $past(wr_ff) && since_ff != CNT_W'(1))
        else $error("Early start was accepted");
    a_start_taken: assert property (@(posedge clk_sys) disable iff (!rst_b)
        accept |=> busy_ff[$past(wr_ff)] && smp_ff[$past(wr_ff)] == $past(sample_in))
        else $error("Accepted start did not capture sample");
    a_overlap_ok: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rise && (!seen_ff || since_ff >= MINSP_L) && !busy_ff[wr_ff]
        |=> wr_ff == $past(wr_ff) + 1'b1 && since_ff == CNT_W'(1))
        else $error("Spaced start was rejected");
    a_latency_exact: assert property (@(posedge clk_sys) disable iff (!rst_b)
        accept |-> ##(DUE_C) deliver)
        else $error("Result not due at conversion latency");
    a_valid_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        deliver |=> !data_valid)
        else $error("Ready flag did not drop on update");
    a_valid_length: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !data_valid |-> lowrun_ff < VLOW_L)
        else $error("Ready flag low too long");
    a_bus_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(data_out) |-> $past(deliver))
        else $error("Result bus changed outside delivery");
    a_fmt_msb: assert property (@(posedge clk_sys) disable iff (!rst_b)
        deliver |=> data_out[DATA_W-1] == ($past(smp_ff[rd_ff][DATA_W-1]) ^ $past(twos_comp)))
        else $error("Output format wrong");
    a_order_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        deliver |=> rd_ff == $past(rd_ff) + 1'b1)
        else $error("Results out of start order");
    a_valid_return: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(data_valid) |-> lowrun_ff == VLOW_L)
        else $error("Ready flag low time wrong");
    a_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        data_valid && !deliver |=> data_valid)
        else $error("Ready flag dropped without update");
    a_rise_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rise |=> !rise)
        else $error("Strobe edge seen twice");
    a_accept_ptr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !accept |=> wr_ff == $past(wr_ff))
        else $error("Slot written without a start");
    a_due_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        busy_ff[rd_ff] |-> due_ff[rd_ff] <= DUE_L)
        else $error("Oldest result overdue");
endmodule : adc_conversion_timing

//--- tb/adc_result_sink.sv
`timescale 1ns/10ps
module adc_result_sink #(
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              clk_sys,    // System clock
    input  wire logic              rst_b,      // Async reset, active low
    input  wire logic [DATA_W-1:0] data_out,   // Result bus
    input  wire logic              data_valid, // Result ready
    output logic      [DATA_W-1:0] got_code,   // Last delivered code
    output int unsigned            n_got,      // Results taken
    output int unsigned            got_cyc,    // Cycle of last delivery
    output int unsigned            low_len     // Last ready-low length
);
    int unsigned cyc;
    int unsigned low_cnt;
    logic        valid_q;
    // Takes a result on the first cycle the ready flag is seen low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cyc      <= 0;
            valid_q  <= 1'b1;
            got_code <= '0;
            n_got    <= 0;
            got_cyc  <= 0;
            low_cnt  <= 0;
            low_len  <= 0;
        end else begin
            cyc     <= cyc + 1;
            valid_q <= data_valid;
            if (valid_q && !data_valid) begin
                got_code <= data_out;
                n_got    <= n_got + 1;
                got_cyc  <= cyc;
            end
            low_cnt <= data_valid ? 0 : low_cnt + 1;
            if (!valid_q && data_valid) begin
                low_len <= low_cnt;
            end
        end
    end
endmodule : adc_result_sink

//--- tb/adc_conversion_timing_bench.sv
`timescale 1ns/10ps
module adc_conversion_timing_bench;
    import adc_timing_pkg::*;
    typedef struct packed {logic [7:0] smp; logic tc; logic [7:0] exp;} row_t;
    logic        clk_sys = 0, rst_b = 0, strobe_in = 0, twos_comp = 0;
    logic [7:0]  sample_in = '0, data_out, got_code, code1;
    logic        data_valid;
    int unsigned n_got, got_cyc, low_len, c1, n0, lat, cycles = 0, failures = 0, n_checks = 0;
    row_t rows [5] = '{'{8'h00, 1'b0, 8'h00}, '{8'h80, 1'b0, 8'h80}, '{8'h5a, 1'b1, 8'hda},
                       '{8'hff, 1'b1, 8'h7f}, '{8'h01, 1'b1, 8'h81}};
    // Spacing kept below latency by the configurer
    adc_conversion_timing #(.DATA_W(8), .CONV_C(CONV_CYC), .MINSP_C(MIN_START_CYC),
        .VLOW_C(VALID_LOW_CYC)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .strobe_in(strobe_in),
        .sample_in(sample_in), .twos_comp(twos_comp), .data_out(data_out), .data_valid(data_valid));
    adc_result_sink #(.DATA_W(8)) sink_u (.clk_sys(clk_sys), .rst_b(rst_b), .data_out(data_out),
        .data_valid(data_valid), .got_code(got_code), .n_got(n_got), .got_cyc(got_cyc), .low_len(low_len));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // Called at a falling edge; strobe high for two cycles
    task automatic start();
        strobe_in = 1'b1;
        repeat (2) @(negedge clk_sys);
        strobe_in = 1'b0;
    endtask : start
    task automatic wait_got(input int unsigned n);
        int k;
        k = 0;
        while (n_got < n && k < 80) begin
            @(negedge clk_sys);
            k++;
        end
        check("result count", n_got, n);
    endtask : wait_got
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_sys);
        check("reset data", data_out, 0);
        check("reset ready", data_valid, 1);
        rst_b = 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            sample_in = rows[i].smp;
            twos_comp = rows[i].tc;
            n0 = n_got;
            start();
            wait_got(n0 + 1);
            check("code", got_code, rows[i].exp);
            repeat (6) @(negedge clk_sys);
            check("ready low time", low_len, VALID_LOW_CYC);
            check("bus held", data_out, rows[i].exp);
            $display("test row %0d done", i);
        end
        twos_comp = 1'b0;
        // Pin edge to first low ready flag; 1 us ends at negedge CONV_CYC, the update lands half a cycle later, just before negedge CONV_CYC + 1
        n0 = n_got;
        sample_in = 8'h3c;
        strobe_in = 1'b1;
        lat = 0;
        while (data_valid && lat < 60) begin
            @(negedge clk_sys);
            lat++;
            if (lat == 2) begin
                strobe_in = 1'b0;
            end
        end
        check("latency", lat, CONV_CYC + 1);
        wait_got(n0 + 1);
        check("latency code", got_code, 8'h3c);
        $display("test latency done");
        n0 = n_got;
        sample_in = 8'h11;
        start();
        repeat (6) @(negedge clk_sys);
        sample_in = 8'h22;
        repeat (7) @(negedge clk_sys);
        start();
        wait_got(n0 + 1);
        code1 = got_code;
        c1 = got_cyc;
        wait_got(n0 + 2);
        check("first overlap", code1, 8'h11);
        check("second overlap", got_code, 8'h22);
        check("delivery spacing", got_cyc - c1, 15);
        $display("test overlap done");
        n0 = n_got;
        sample_in = 8'h33;
        start();
        repeat (6) @(negedge clk_sys);
        sample_in = 8'h44;
        repeat (4) @(negedge clk_sys);
        start();
        wait_got(n0 + 1);
        repeat (60) @(negedge clk_sys);
        check("early start count", n_got, n0 + 1);
        check("early start code", got_code, 8'h33);
        $display("test early start done");
        // Thirteen cycles is 520 ns, beyond the minimum spacing
        n0 = n_got;
        sample_in = 8'h55;
        start();
        repeat (6) @(negedge clk_sys);
        sample_in = 8'h66;
        repeat (5) @(negedge clk_sys);
        start();
        wait_got(n0 + 1);
        code1 = got_code;
        wait_got(n0 + 2);
        check("boundary first", code1, 8'h55);
        check("boundary second", got_code, 8'h66);
        $display("test spacing boundary done");
        // Reset with a conversion in flight, then a start at release
        sample_in = 8'h77;
        start();
        repeat (8) @(negedge clk_sys);
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("mid reset data", data_out, 0);
        check("mid reset ready", data_valid, 1);
        rst_b = 1'b1;
        sample_in = 8'h5c;
        start();
        wait_got(1);
        repeat (40) @(negedge clk_sys);
        check("after reset count", n_got, 1);
        check("after reset code", got_code, 8'h5c);
        $display("test mid reset done");
        close_out();
    end
endmodule : adc_conversion_timing_bench
